//--- spf_map.svh
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH

// rate select codes
`define SPF_RATE_DIVIDE_BY_TWO 2'h0
`define SPF_RATE_DIVIDE_BY_EIGHT 2'h1
`define SPF_RATE_DIVIDE_BY_THIRTY_TWO 2'h2
`define SPF_RATE_DIVIDE_BY_ONE_TWENTY_EIGHT 2'h3

// last count of the free running divider, one serial bit time minus one
`define SPF_LAST_DIVIDE_BY_TWO 7'h01
`define SPF_LAST_DIVIDE_BY_EIGHT 7'h07
`define SPF_LAST_DIVIDE_BY_THIRTY_TWO 7'h1f
`define SPF_LAST_DIVIDE_BY_ONE_TWENTY_EIGHT 7'h7f

// clock edges in one byte, the last of them ends the transfer
`define SPF_EDGE_FIRST 5'h01
`define SPF_EDGE_LAST 5'h10

// reset values
`define SPF_RST_BYTE 8'h00
`define SPF_RST_DIV 7'h00
`define SPF_RST_EDGE 5'h00

`endif

//--- spf_peer.sv
`timescale 1ns/10ps
// peer slave facing a master transfer
module spf_peer
(
    input wire logic sclk,
    input wire logic mosi,
    input wire logic pha,
    input wire logic ld,
    input wire logic [7:0] load,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] sr;
    int n;
    // reload before a frame
    always @(posedge ld)
    begin
        sr = load;
        n = 0;
    end
    // capture on odd edges in phase 0, even in phase 1; first phase 1 edge only starts
    always @(sclk)
    begin
        n = n + 1;
        if (n[0] ^ pha)
            got = {got[6:0], mosi};
        else if (n > 1 || !pha)
            sr = {sr[6:0], ~sr[0]};
    end
    assign miso = sr[7];
endmodule

//--- spf_pkg.sv
package spf_pkg;

    // transfer sequencer states, one-hot
    typedef enum logic [1:0] {
        SPF_IDLE = 2'b01,
        SPF_RUN = 2'b10
    } spf_state_t;

    // format and mode controls
    typedef struct packed {
        logic module_enable_bit;
        logic master_select_bit;
        logic clock_idle_polarity;
        logic clock_phase_select;
        logic [1:0] rate_select_bits;
    } spf_ctrl_t;

    // one serial pin seen as output and output enable
    typedef struct packed {
        logic o;
        logic oe;
    } spf_pin_out_t;

    // whole state of the transfer logic
    typedef struct packed {
        spf_state_t state;
        logic [6:0] div_cnt;
        logic [4:0] edge_cnt;
        logic act;
        logic [7:0] shift;
        logic cap;
        logic shift_full;
        logic tx_full;
        logic [7:0] tx_buf;
        logic [7:0] rx_data;
        logic rx_full;
        logic sck_prev;
        logic ss_prev_b;
    } spf_core_st_t;

endpackage

//--- spf_transfer_format.sv
`timescale 1ns/10ps
`include "spf_map.svh"

// byte queue in front of the transmit data register
module spf_fifo
    import spf_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } spf_fifo_st_t;

    spf_fifo_st_t q;
    spf_fifo_st_t d;
    logic full;
    logic empty;

    // full when pointers differ only in the wrap bit
    assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    assign empty = (q.wp == q.rp);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = q.mem[q.rp[AW-1:0]];

    // push and pop
    always_comb
    begin
        d = q;
        if (in_valid && !full)
        begin
            d.mem[q.wp[AW-1:0]] = in_data;
            d.wp = q.wp + 1'b1;
        end
        if (out_ready && !empty)
        begin
            d.rp = q.rp + 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end
endmodule

module spf_transfer_format
    import spf_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire spf_ctrl_t ctrl,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    output logic transmit_empty_flag,
    output logic [7:0] rx_data,
    output logic receive_full_flag,
    input wire logic rx_ack,
    output logic busy,
    input wire logic shift_clock_pin_i,
    output spf_pin_out_t shift_clock_pin,
    input wire logic mosi_i,
    output spf_pin_out_t mosi,
    input wire logic miso_i,
    output spf_pin_out_t miso,
    input wire logic select_in_b
);
    spf_core_st_t q;
    spf_core_st_t d;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic [6:0] div_last;
    logic [6:0] div_half;
    logic clk_run;
    logic full_tick;
    logic mtick;
    logic stick;
    logic edge_hit;
    logic sdi;
    logic [4:0] k;
    logic capture;
    logic [7:0] done_byte;

    // transmit bytes wait here until the data register is free
    spf_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(fifo_valid),
        .out_ready(!q.tx_full),
        .out_data(fifo_data)
    );

    // divider length per rate code
    always_comb
    begin
        case (ctrl.rate_select_bits)
            `SPF_RATE_DIVIDE_BY_TWO: div_last = `SPF_LAST_DIVIDE_BY_TWO;
            `SPF_RATE_DIVIDE_BY_EIGHT: div_last = `SPF_LAST_DIVIDE_BY_EIGHT;
            `SPF_RATE_DIVIDE_BY_THIRTY_TWO: div_last = `SPF_LAST_DIVIDE_BY_THIRTY_TWO;
            default: div_last = `SPF_LAST_DIVIDE_BY_ONE_TWENTY_EIGHT;
        endcase
    end

    // half bit and full bit ticks of the master clock
    assign div_half = div_last >> 1;
    assign clk_run = ctrl.module_enable_bit && ctrl.master_select_bit;
    assign full_tick = clk_run && (q.div_cnt == div_last);
    assign mtick = clk_run && ((q.div_cnt == div_half) || full_tick);
    // slave sees an edge whenever the clock pin changes
    assign stick = ctrl.module_enable_bit && !ctrl.master_select_bit
        && (shift_clock_pin_i != q.sck_prev);
    assign edge_hit = ctrl.master_select_bit ? mtick : stick;
    assign sdi = ctrl.master_select_bit ? miso_i : mosi_i;
    assign k = q.edge_cnt + `SPF_EDGE_FIRST;
    // odd edges capture in phase 0, even edges in phase 1
    assign capture = ctrl.clock_phase_select ? !k[0] : k[0];
    assign done_byte = ctrl.clock_phase_select ? {q.shift[6:0], sdi}
        : {q.shift[6:0], q.cap};

    // next state
    always_comb
    begin
        d = q;
        d.sck_prev = shift_clock_pin_i;
        d.ss_prev_b = select_in_b;
        // free running divider, stopped unless enabled master
        if (clk_run)
        begin
            d.div_cnt = full_tick ? `SPF_RST_DIV : q.div_cnt + 7'h01;
        end
        else
        begin
            d.div_cnt = `SPF_RST_DIV;
        end
        // queue head moves into the transmit data register
        if (fifo_valid && !q.tx_full)
        begin
            d.tx_full = 1'b1;
            d.tx_buf = fifo_data;
        end
        // software read of the received byte
        if (rx_ack)
        begin
            d.rx_full = 1'b0;
        end
        case (q.state)
            SPF_IDLE:
            begin
                d.act = 1'b0;
                d.edge_cnt = `SPF_RST_EDGE;
                // shifter takes the byte only while idle
                if (q.tx_full && !q.shift_full)
                begin
                    d.shift = q.tx_buf;
                    d.shift_full = 1'b1;
                    d.tx_full = 1'b0;
                end
                if (clk_run && q.shift_full && full_tick)
                begin
                    d.state = SPF_RUN;
                end
                else if (ctrl.module_enable_bit && !ctrl.master_select_bit)
                begin
                    if (!ctrl.clock_phase_select && q.ss_prev_b && !select_in_b)
                    begin
                        d.state = SPF_RUN;
                    end
                    else if (ctrl.clock_phase_select && stick && !select_in_b)
                    begin
                        d.state = SPF_RUN;
                        d.edge_cnt = `SPF_EDGE_FIRST;
                    end
                end
            end
            SPF_RUN:
            begin
                if (!ctrl.module_enable_bit
                    || (!ctrl.master_select_bit && select_in_b))
                begin
                    d.state = SPF_IDLE;
                    d.act = 1'b0;
                end
                else if (edge_hit)
                begin
                    d.edge_cnt = k;
                    d.act = !q.act;
                    if (capture)
                    begin
                        d.cap = sdi;
                    end
                    else if (k != `SPF_EDGE_FIRST)
                    begin
                        d.shift = {q.shift[6:0], q.cap};
                    end
                    if (k == `SPF_EDGE_LAST)
                    begin
                        d.shift = done_byte;
                        d.state = SPF_IDLE;
                        d.shift_full = 1'b0;
                        d.act = 1'b0;
                        if (!q.rx_full)
                        begin
                            d.rx_data = done_byte;
                            d.rx_full = 1'b1;
                        end
                    end
                end
            end
            default:
            begin
                d.state = SPF_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q.state <= SPF_IDLE;
            q.div_cnt <= `SPF_RST_DIV;
            q.edge_cnt <= `SPF_RST_EDGE;
            q.act <= 1'b0;
            q.shift <= `SPF_RST_BYTE;
            q.cap <= 1'b0;
            q.shift_full <= 1'b0;
            q.tx_full <= 1'b0;
            q.tx_buf <= `SPF_RST_BYTE;
            q.rx_data <= `SPF_RST_BYTE;
            q.rx_full <= 1'b0;
            q.sck_prev <= 1'b0;
            q.ss_prev_b <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // status
    assign transmit_empty_flag = !q.tx_full;
    assign rx_data = q.rx_data;
    assign receive_full_flag = q.rx_full;
    assign busy = (q.state == SPF_RUN);

    // pins: polarity only inverts the clock level
    assign shift_clock_pin.o = ctrl.clock_idle_polarity ^ q.act;
    assign shift_clock_pin.oe = clk_run;
    assign mosi.o = q.shift[7];
    assign mosi.oe = clk_run;
    assign miso.o = q.shift[7];
    assign miso.oe = ctrl.module_enable_bit && !ctrl.master_select_bit
        && !select_in_b;
endmodule

//--- spf_transfer_format_assertions.sv
`timescale 1ns/10ps
module spf_transfer_format_assertions
    import spf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire spf_ctrl_t ctrl,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic transmit_empty_flag,
    input wire logic [7:0] rx_data,
    input wire logic receive_full_flag,
    input wire logic rx_ack,
    input wire logic busy,
    input wire logic shift_clock_pin_i,
    input wire spf_pin_out_t shift_clock_pin,
    input wire logic mosi_i,
    input wire spf_pin_out_t mosi,
    input wire logic miso_i,
    input wire spf_pin_out_t miso,
    input wire logic select_in_b
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    logic mst;
    // enabled master
    assign mst = ctrl.module_enable_bit & ctrl.master_select_bit;
    // byte lands in an idle master shifter
    sequence s_load;
        mst && !busy && $rose(transmit_empty_flag);
    endsequence
    // master frame starts at the fastest rate
    sequence s_fast;
        mst && $rose(busy) && ctrl.rate_select_bits == 2'h0;
    endsequence
    a_miso_select: assert property (
        miso.oe == (ctrl.module_enable_bit && !ctrl.master_select_bit && !select_in_b))
        else $error("miso drive does not follow select");
    a_master_pins: assert property (
        shift_clock_pin.oe == mst && mosi.oe == mst)
        else $error("master pin enables wrong");
    a_clock_idle: assert property (
        mst && !busy && !$past(busy) |-> shift_clock_pin.o == ctrl.clock_idle_polarity)
        else $error("idle clock level wrong");
    a_phase0_lead: assert property (
        mst && !ctrl.clock_phase_select && $rose(busy)
        |-> shift_clock_pin.o == ctrl.clock_idle_polarity)
        else $error("phase 0 clock not idle at start");
    a_start_delay: assert property (
        s_load |-> ##[1:130] busy)
        else $error("master start too late");
    a_frame_length: assert property (
        s_fast |-> busy [*8] ##[6:12] !busy)
        else $error("fast frame length wrong");
    a_rx_update: assert property (
        !$stable(rx_data) |-> $rose(receive_full_flag))
        else $error("receive data moved without flag");
    a_rx_clear: assert property (
        rx_ack && !busy |=> !receive_full_flag)
        else $error("receive flag not cleared");
    a_load_blocked: assert property (
        busy && !transmit_empty_flag |=> !transmit_empty_flag)
        else $error("shifter loaded during transfer");
endmodule

bind spf_transfer_format spf_transfer_format_assertions u_chk (.*);

//--- spf_transfer_format_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
$display("unexpected %s exp %h seen %h", nm, e, s); end end
module spf_transfer_format_bench
    import spf_pkg::*;
;
    logic core_clk = 0, rst_b = 0, tx_valid = 0, rx_ack = 0, sck_in = 0;
    logic mosi_in = 0, sel_b = 1, ld = 0, miso_p, tx_ready, tx_empty, rx_full, busy;
    logic [7:0] tx_data = 0, rx_data, pload = 0, got, s, pe;
    spf_ctrl_t ctrl = '0;
    spf_pin_out_t sck_o, mosi_o, miso_o;
    int miscompares = 0, n_compared = 0, n;
    spf_transfer_format uut (.core_clk(core_clk), .rst_b(rst_b), .ctrl(ctrl),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .transmit_empty_flag(tx_empty), .rx_data(rx_data), .receive_full_flag(rx_full),
        .rx_ack(rx_ack), .busy(busy), .shift_clock_pin_i(sck_in), .shift_clock_pin(sck_o),
        .mosi_i(mosi_in), .mosi(mosi_o), .miso_i(miso_p), .miso(miso_o),
        .select_in_b(sel_b));
    spf_peer peer (.sclk(sck_o.o), .mosi(mosi_o.o), .pha(ctrl.clock_phase_select),
        .ld(ld), .load(pload), .miso(miso_p), .got(got));
    always #2 core_clk = ~core_clk;
    task tick(input int c);
        repeat (c) @(negedge core_clk);
    endtask
    // offer one byte and hold it until taken
    task put(input logic [7:0] b);
        tx_valid = 1'b1;
        tx_data = b;
        @(posedge core_clk);
        while (tx_ready !== 1'b1)
            @(posedge core_clk);
        @(negedge core_clk);
        tx_valid = 1'b0;
    endtask
    // wait for a received byte, then release it; slowest frame is over 1000 cycles
    task take(input logic [7:0] e);
        for (int i = 0; i < 2000 && rx_full !== 1'b1; i++)
            tick(1);
        `CHK("rx_data", e, rx_data)
        rx_ack = 1'b1;
        tick(1);
        rx_ack = 1'b0;
    endtask
    // reconfigure with the module off first
    task cfg(input logic m, input logic p, input logic h, input logic [1:0] r);
        ctrl = '{1'b0, m, p, h, r};
        sck_in = p;
        tick(2);
        ctrl.module_enable_bit = 1'b1;
        tick(2);
    endtask
    // one byte as the far master clocking a slave
    task xfer(input logic [7:0] m);
        for (int i = 7; i >= 0; i--)
        begin
            if (ctrl.clock_phase_select)
                sck_in = ~sck_in;
            tick(3);
            mosi_in = m[i];
            s[i] = miso_o.o;
            tick(1);
            sck_in = ~sck_in;
            tick(3);
            if (!ctrl.clock_phase_select)
            begin
                sck_in = ~sck_in;
                tick(3);
            end
        end
        mosi_in = ~mosi_in;
        take(m);
    endtask
    task summarize;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        summarize();
    end
    initial
    begin
        tick(20);
        rst_b = 1'b1;
        `CHK("tx empty", 1'b1, tx_empty)
        `CHK("rx full", 1'b0, rx_full)
        // every rate, phase and polarity as master; select held high
        for (int k = 0; k < 8; k++)
        begin
            cfg(1'b1, k[2], k[0], k[2:1]);
            pload = 8'h5a ^ 8'(k);
            ld = 1'b1;
            tick(1);
            ld = 1'b0;
            put(8'hc3 + 8'(k));
            tick(3);
            `CHK("tx empty", 1'b1, tx_empty)
            take(pload);
            `CHK("peer byte", 8'hc3 + 8'(k), got)
        end
        // phase 0 slave: start on select fall, late byte held
        cfg(1'b0, 1'b0, 1'b0, 2'h0);
        `CHK("miso oe", 1'b0, miso_o.oe)
        put(8'ha5);
        tick(4);
        sel_b = 1'b0;
        tick(3);
        `CHK("miso oe", 1'b1, miso_o.oe)
        `CHK("miso msb", 1'b1, miso_o.o)
        put(8'h96);
        xfer(8'h3c);
        `CHK("slave out", 8'ha5, s)
        sel_b = 1'b1;
        tick(3);
        sel_b = 1'b0;
        tick(3);
        xfer(8'h0f);
        `CHK("slave out", 8'h96, s)
        sel_b = 1'b1;
        // phase 1 slave, select low across two bytes
        cfg(1'b0, 1'b1, 1'b1, 2'h0);
        put(8'h81);
        tick(4);
        sel_b = 1'b0;
        xfer(8'h7e);
        `CHK("slave out", 8'h81, s)
        put(8'h42);
        tick(4);
        xfer(8'he1);
        `CHK("slave out", 8'h42, s)
        sel_b = 1'b1;
        // fill the queue while off, then drain as master
        ctrl = '0;
        sck_in = 1'b0;
        tick(2);
        tx_valid = 1'b1;
        n = 0;
        while (tx_ready === 1'b1 && n < 40)
        begin
            tx_data = 8'(n);
            tick(1);
            n++;
        end
        tx_valid = 1'b0;
        `CHK("queue size", 1'b1, n >= 32 && n < 40)
        cfg(1'b1, 1'b0, 1'b0, 2'h0);
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
        // the peer answers with its reload value, shifted eight places per byte
        pe = pload;
        for (int j = 0; j < n; j++)
        begin
            take(pe);
            repeat (8) pe = {pe[6:0], ~pe[0]};
        end
        `CHK("last byte", 8'(n - 1), got)
        `CHK("tx empty", 1'b1, tx_empty)
        summarize();
    end
endmodule
